// ===== hw/vosg_regs.sv
`timescale 1ns/1ps
// output format, vertical scaling and gate delay register bank
module vosg_regs
(
    input  wire logic                        sys_clk_in,        // 250 MHz clock
    input  wire logic                        rst_in,            // sync reset, high
    // apb slave
    input  wire logic                        psel,              // select
    input  wire logic                        penable,           // access phase
    input  wire logic                        pwrite,            // write
    input  wire logic [11:0]                 paddr,             // byte address
    input  wire logic [31:0]                 pwdata,            // write data
    input  wire logic [3:0]                  pstrb,             // byte strobes
    output logic                             pready,            // always ready
    output logic      [31:0]                 prdata,            // read data
    output logic                             pslverr,           // unmapped
    // video path
    input  wire logic                        odd_field_in,      // field now
    input  wire logic [vosg_pkg::PIX_AW-1:0] pix_idx_in,        // pixel in line
    input  wire logic [7:0]                  luma_in,           // raw luma
    input  wire logic [7:0]                  chroma_in,         // raw chroma
    output logic      [7:0]                  luma_out,          // shaped luma
    output logic      [7:0]                  chroma_out,        // combed chroma
    // scaler and gate controls
    output logic      [12:0]                 vert_ratio_value_out,
    output vosg_pkg::vosg_scale_mode_t       scale_mode_out,
    output logic      [7:0]                  agc_gate_count_out,
    output logic      [7:0]                  burst_gate_count_out
);
    // ********************************
    // register storage
    // ********************************
    logic [7:0] output_format_reg_q;          // range and coring
    logic [7:0] vs_high_q [2];                // [0] even, [1] odd
    logic [7:0] vs_low_q  [2];                // [0] even, [1] odd
    logic [7:0] agc_gate_count_q;             // back porch gate
    logic [7:0] burst_gate_count_q;           // burst gate
    logic [31:0] prdata_q;                    // read data

    logic        wr_en;                       // write accepted
    logic        rd_en;                       // read accepted
    logic        lane0;                       // low byte strobed
    logic        soft_reset_command;          // write to reset address
    logic        any_rst;                     // hw or soft reset
    logic        hit;                         // mapped address
    logic [7:0]  rd_byte;                     // selected read
    logic        fsel;                        // active field copy

    // zero wait states: every access completes on its first access edge
    assign pready = 1'b1;
    assign wr_en  = psel & penable & pwrite;
    assign rd_en  = psel & penable & ~pwrite;
    assign lane0  = pstrb[0];
    assign soft_reset_command = wr_en & (paddr == vosg_pkg::OFS_SOFT_RESET);
    assign any_rst = rst_in | soft_reset_command;

    // ********************************
    // address decode and read mux
    // ********************************
    always_comb
    begin
        hit     = 1'b1;
        rd_byte = 8'h00;
        unique case (paddr)
            vosg_pkg::OFS_OUTPUT_FORMAT: rd_byte = output_format_reg_q;
            vosg_pkg::OFS_VS_HIGH_EVEN:  rd_byte = vs_high_q[0];
            vosg_pkg::OFS_VS_LOW_EVEN:   rd_byte = vs_low_q[0];
            vosg_pkg::OFS_FACTORY_TEST:  rd_byte = vosg_pkg::TEST_READ_VALUE;
            vosg_pkg::OFS_AGC_GATE:      rd_byte = agc_gate_count_q;
            vosg_pkg::OFS_BURST_GATE:    rd_byte = burst_gate_count_q;
            vosg_pkg::OFS_SOFT_RESET:    rd_byte = 8'h00;  // undefined, reads zero
            vosg_pkg::OFS_VS_HIGH_ODD:   rd_byte = vs_high_q[1];
            vosg_pkg::OFS_VS_LOW_ODD:    rd_byte = vs_low_q[1];
            default:                     hit     = 1'b0;
        endcase
    end

    // read data held after the access edge
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            prdata_q <= 32'h0000_0000;
        else if (rd_en)
            prdata_q <= {24'h00_0000, rd_byte};
    end
    // combinational answer so data is valid on the completing edge
    assign prdata  = rd_en ? {24'h00_0000, rd_byte} : prdata_q;
    assign pslverr = psel & penable & ~hit;

    // ********************************
    // output format register
    // ********************************
    // reserved low bits stored as written; software keeps them zero
    always_ff @(posedge sys_clk_in)
    begin
        if (any_rst)
            output_format_reg_q <= vosg_pkg::RST_OUTPUT_FORMAT;
        else if (wr_en && lane0 && paddr == vosg_pkg::OFS_OUTPUT_FORMAT)
            output_format_reg_q <= pwdata[7:0];
    end

    // ********************************
    // vertical scaling, per field copy
    // ********************************
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_field
            localparam logic [11:0] HI_OFS = (g == 0) ? vosg_pkg::OFS_VS_HIGH_EVEN
                                                      : vosg_pkg::OFS_VS_HIGH_ODD;
            localparam logic [11:0] LO_OFS = (g == 0) ? vosg_pkg::OFS_VS_LOW_EVEN
                                                      : vosg_pkg::OFS_VS_LOW_ODD;
            always_ff @(posedge sys_clk_in)
            begin
                if (any_rst)
                begin
                    vs_high_q[g] <= vosg_pkg::RST_VS_HIGH;
                    vs_low_q[g]  <= vosg_pkg::RST_VS_LOW;
                end
                else if (wr_en && lane0)
                begin
                    if (paddr == HI_OFS)
                        vs_high_q[g] <= pwdata[7:0];
                    if (paddr == LO_OFS)
                        vs_low_q[g] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    // ********************************
    // gate delay counts
    // ********************************
    // agc default is 0x68; 0x70 is only a typical ntsc setting
    always_ff @(posedge sys_clk_in)
    begin
        if (any_rst)
        begin
            agc_gate_count_q   <= vosg_pkg::RST_AGC_GATE;
            burst_gate_count_q <= vosg_pkg::RST_BURST_GATE;
        end
        else if (wr_en && lane0)
        begin
            if (paddr == vosg_pkg::OFS_AGC_GATE)
                agc_gate_count_q <= pwdata[7:0];
            if (paddr == vosg_pkg::OFS_BURST_GATE)
                burst_gate_count_q <= pwdata[7:0];
        end
    end
    // test register writes are dropped: no test mode exists here
    assign agc_gate_count_out   = agc_gate_count_q;
    assign burst_gate_count_out = burst_gate_count_q;

    // ********************************
    // field-selected scaler controls
    // ********************************
    assign fsel = odd_field_in;
    // registered so the scaler never sees a half-switched field
    logic [12:0]                 ratio_q;     // selected ratio
    vosg_pkg::vosg_scale_mode_t  mode_q;      // selected mode
    logic                        comb_q;      // selected comb enable
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            ratio_q <= 13'h0000;
            mode_q  <= vosg_pkg::VOSG_SCALE_INT;
            comb_q  <= 1'b1;
        end
        else
        begin
            ratio_q <= {vs_high_q[fsel][4:0], vs_low_q[fsel]};
            comb_q  <= vs_high_q[fsel][vosg_pkg::BIT_COMB];
            if (vs_high_q[fsel][vosg_pkg::BIT_INTERLACE])
                mode_q <= vosg_pkg::VOSG_SCALE_INT;
            else if (vs_high_q[fsel][vosg_pkg::BIT_FLD_ALIGN])
                mode_q <= vosg_pkg::VOSG_SCALE_FLD;
            else
                mode_q <= vosg_pkg::VOSG_SCALE_NONINT;
        end
    end
    assign vert_ratio_value_out = ratio_q;
    assign scale_mode_out       = mode_q;

    // ********************************
    // pixel datapath
    // ********************************
    vosg_luma_shape u_luma
    (
        .sys_clk_in    (sys_clk_in),
        .rst_in        (rst_in),
        .luma_in       (luma_in),
        .full_range_in (output_format_reg_q[vosg_pkg::BIT_RANGE]),
        .core_sel_in   (output_format_reg_q[vosg_pkg::BIT_CORE_LO +: 2]),
        .luma_out      (luma_out)
    );

    vosg_chroma_comb u_chroma
    (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .comb_en_in (comb_q),
        .pix_idx_in (pix_idx_in),
        .chroma_in  (chroma_in),
        .chroma_out (chroma_out)
    );

    // ********************************
    // checks
    // ********************************
    a_test_reads_one: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        rd_en && paddr == vosg_pkg::OFS_FACTORY_TEST |-> prdata == 32'h0000_0001)
        else $error("test register read not 0x01");
    a_soft_reset_agc: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        soft_reset_command |=> agc_gate_count_q == 8'h68 && burst_gate_count_q == 8'h5D)
        else $error("soft reset did not restore gate counts");
    a_soft_reset_vs: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        soft_reset_command |=> vs_high_q[0] == 8'h60 && vs_low_q[1] == 8'h00)
        else $error("soft reset did not restore scaling");
    a_ratio_concat: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ##1 vert_ratio_value_out == {$past(vs_high_q[fsel][4:0]), $past(vs_low_q[fsel])})
        else $error("ratio not formed from selected field");
    a_write_back: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr_en && lane0 && paddr == vosg_pkg::OFS_BURST_GATE
        |=> burst_gate_count_q == $past(pwdata[7:0]))
        else $error("burst count write lost");
    a_mode_interlace: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        vs_high_q[fsel][5] |=> scale_mode_out == vosg_pkg::VOSG_SCALE_INT)
        else $error("interlace bit ignored");
    a_luma_limited: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (!rst_in && !output_format_reg_q[7]) ##1 !output_format_reg_q[7]
        |-> luma_out >= 8'h10)
        else $error("limited luma below 16");
    a_chroma_range: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ##1 chroma_out >= 8'h02 && chroma_out <= 8'hFD)
        else $error("chroma out of range");
    a_core_full: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        output_format_reg_q == 8'hE0 && luma_in < 8'h20 |=> luma_out == 8'h00)
        else $error("coring did not zero luma");
endmodule

// ===== hw/vosg_pkg.sv
// Contract
// - range bit selects limited or full luma
// - zero colour encodes as 128 chroma
// - coring forces luma zero below limit in full range
// - coring field picks limit 0/8/16/32
// - bits 7 and 5 select scaling mode
// - comb enable averages adjacent chroma lines
// - ratio is five upper plus eight lower
// - separate even and odd scaling copies
// - upper resets 0x60, lower resets zero
// - test register always reads 0x01
// - agc count sets back porch gate
// - burst count sets subcarrier gate
// - burst resets 0x5D, format resets 0x00
// - agc delay resets 0x68, not 0x70
// - soft reset write restores all defaults
package vosg_pkg;
    // ********************************
    // register byte offsets
    // ********************************
    localparam logic [11:0] OFS_OUTPUT_FORMAT  = 12'h048;
    localparam logic [11:0] OFS_VS_HIGH_EVEN   = 12'h04C;
    localparam logic [11:0] OFS_VS_LOW_EVEN    = 12'h050;
    localparam logic [11:0] OFS_FACTORY_TEST   = 12'h054;
    localparam logic [11:0] OFS_AGC_GATE       = 12'h060;
    localparam logic [11:0] OFS_BURST_GATE     = 12'h064;
    localparam logic [11:0] OFS_SOFT_RESET     = 12'h07C;
    localparam logic [11:0] OFS_VS_HIGH_ODD    = 12'h0CC;
    localparam logic [11:0] OFS_VS_LOW_ODD     = 12'h0D0;
    // ********************************
    // reset values
    // ********************************
    localparam logic [7:0]  RST_OUTPUT_FORMAT  = 8'h00;
    localparam logic [7:0]  RST_VS_HIGH        = 8'h60;
    localparam logic [7:0]  RST_VS_LOW         = 8'h00;
    localparam logic [7:0]  RST_AGC_GATE       = 8'h68;
    localparam logic [7:0]  RST_BURST_GATE     = 8'h5D;
    localparam logic [7:0]  TEST_READ_VALUE    = 8'h01;
    // ********************************
    // field positions
    // ********************************
    localparam int          BIT_RANGE          = 7;
    localparam int          BIT_CORE_LO        = 5;
    localparam int          BIT_FLD_ALIGN      = 7;
    localparam int          BIT_COMB           = 6;
    localparam int          BIT_INTERLACE      = 5;
    // ********************************
    // video levels
    // ********************************
    localparam logic [7:0]  LUMA_MIN_LIMITED   = 8'h10;
    localparam logic [7:0]  LUMA_MAX_LIMITED   = 8'hFD;
    localparam logic [7:0]  CHROMA_MIN         = 8'h02;
    localparam logic [7:0]  CHROMA_MAX         = 8'hFD;
    localparam logic [7:0]  CHROMA_ZERO        = 8'h80;
    localparam logic [7:0]  CORE_LIMIT_1       = 8'h08;
    localparam logic [7:0]  CORE_LIMIT_2       = 8'h10;
    localparam logic [7:0]  CORE_LIMIT_3       = 8'h20;
    localparam int          LINE_PIXELS        = 1024;
    localparam int          PIX_AW             = 10;
    // scaling modes
    typedef enum logic [1:0]
    {
        VOSG_SCALE_NONINT = 2'b00,
        VOSG_SCALE_INT    = 2'b01,
        VOSG_SCALE_FLD    = 2'b11
    } vosg_scale_mode_t;
endpackage

// ===== hw/vosg_luma_shape.sv
`timescale 1ns/1ps
// luma coring and range limiting, one pixel per clock
module vosg_luma_shape
(
    input  wire logic       sys_clk_in,      // system clock
    input  wire logic       rst_in,          // sync reset
    input  wire logic [7:0] luma_in,         // raw luma
    input  wire logic       full_range_in,   // 1: 0..255
    input  wire logic [1:0] core_sel_in,     // coring select
    output logic      [7:0] luma_out         // shaped luma
);
    logic [7:0] limit;                        // coring threshold
    logic [7:0] cored;                        // after coring
    logic [7:0] luma_q;                       // output register

    // ********************************
    // coring limit decode
    // ********************************
    always_comb
    begin
        unique case (core_sel_in)
            2'b00:   limit = 8'h00;
            2'b01:   limit = vosg_pkg::CORE_LIMIT_1;
            2'b10:   limit = vosg_pkg::CORE_LIMIT_2;
            2'b11:   limit = vosg_pkg::CORE_LIMIT_3;
        endcase
        // below threshold truncates to zero
        cored = (luma_in < limit) ? 8'h00 : luma_in;
    end

    // limited range clamps after coring, so cored black lands on 16
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            luma_q <= 8'h00;
        else if (full_range_in)
            luma_q <= cored;
        else if (cored < vosg_pkg::LUMA_MIN_LIMITED)
            luma_q <= vosg_pkg::LUMA_MIN_LIMITED;
        else if (cored > vosg_pkg::LUMA_MAX_LIMITED)
            luma_q <= vosg_pkg::LUMA_MAX_LIMITED;
        else
            luma_q <= cored;
    end
    assign luma_out = luma_q;
endmodule

// ===== hw/vosg_chroma_comb.sv
`timescale 1ns/1ps
// chroma comb: a line store and two-line averaging, or bypass
module vosg_chroma_comb
(
    input  wire logic                         sys_clk_in,  // system clock
    input  wire logic                         rst_in,      // sync reset
    input  wire logic                         comb_en_in,  // comb enable
    input  wire logic [vosg_pkg::PIX_AW-1:0]  pix_idx_in,  // pixel in line
    input  wire logic [7:0]                   chroma_in,   // offset-binary chroma
    output logic      [7:0]                   chroma_out   // clamped chroma
);
    logic [7:0] line_mem [vosg_pkg::LINE_PIXELS]; // full line store
    logic [7:0] prev;                             // same pixel, last line
    logic [8:0] sum;                              // two-line sum
    logic [7:0] pick;                             // comb or bypass
    logic [7:0] chroma_q;                         // output register

    // line store, no reset: contents only matter after one line
    always_ff @(posedge sys_clk_in)
    begin
        line_mem[pix_idx_in] <= chroma_in;
    end

    always_comb
    begin
        prev = line_mem[pix_idx_in];
        sum  = {1'b0, chroma_in} + {1'b0, prev};
        pick = comb_en_in ? sum[8:1] : chroma_in;
    end

    // clamp keeps chroma 2..253, 128 stays zero colour
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            chroma_q <= vosg_pkg::CHROMA_ZERO;
        else if (pick < vosg_pkg::CHROMA_MIN)
            chroma_q <= vosg_pkg::CHROMA_MIN;
        else if (pick > vosg_pkg::CHROMA_MAX)
            chroma_q <= vosg_pkg::CHROMA_MAX;
        else
            chroma_q <= pick;
    end
    assign chroma_out = chroma_q;
endmodule

// ===== tb/vosg_tb.sv
`timescale 1ns/1ps
module testbench;
    // ****************************************
    // clock, reset and dut wiring
    // ****************************************
    logic                        sys_clk_in   = 1'b0;  // 250 MHz
    logic                        rst_in       = 1'b1;  // sync reset
    logic                        psel         = 1'b0;  // apb select
    logic                        penable      = 1'b0;  // apb access phase
    logic                        pwrite       = 1'b0;  // apb direction
    logic [11:0]                 paddr        = 12'h000;
    logic [31:0]                 pwdata       = 32'h0000_0000;
    logic [3:0]                  pstrb        = 4'hF;
    logic                        pready;               // slave answer
    logic [31:0]                 prdata;               // read data
    logic                        pslverr;              // unmapped flag
    logic                        odd_field_in = 1'b0;  // field selector
    logic [vosg_pkg::PIX_AW-1:0] pix_idx_in   = '0;    // pixel index
    logic [7:0]                  luma_in      = 8'h00;
    logic [7:0]                  chroma_in    = 8'h80;
    logic [7:0]                  luma_out;
    logic [7:0]                  chroma_out;
    logic [12:0]                 ratio;                // scaler ratio
    vosg_pkg::vosg_scale_mode_t  mode;                 // scaler mode
    logic [7:0]                  agc_cnt;              // agc gate count out
    logic [7:0]                  burst_cnt;            // burst gate count out
    int                          num_errors   = 0;     // mismatches
    int                          checked      = 0;     // comparisons
    int                          cycles       = 0;     // hang guard
    // register offsets, defaults and a write pattern, same order
    logic [11:0] ofs_v [8] = '{vosg_pkg::OFS_OUTPUT_FORMAT, vosg_pkg::OFS_VS_HIGH_EVEN,
        vosg_pkg::OFS_VS_LOW_EVEN, vosg_pkg::OFS_FACTORY_TEST, vosg_pkg::OFS_AGC_GATE,
        vosg_pkg::OFS_BURST_GATE, vosg_pkg::OFS_VS_HIGH_ODD, vosg_pkg::OFS_VS_LOW_ODD};
    logic [7:0]  rst_v [8] = '{8'h00, 8'h60, 8'h00, 8'h01, 8'h68, 8'h5D, 8'h60, 8'h00};
    logic [7:0]  pat_v [8] = '{8'hE0, 8'hB5, 8'h5A, 8'h01, 8'hC3, 8'h3C, 8'h9F, 8'hF0};
    // luma and chroma table: format, luma in, luma expected, chroma in, chroma expected
    logic [39:0] shp_v [11] = '{40'h00_00_10_80_80, 40'h00_FF_FD_00_02,
        40'h00_80_80_FF_FD, 40'h80_00_00_80_80, 40'h80_FF_FF_FF_FD, 40'hA0_07_00_00_02,
        40'hA0_08_08_80_80, 40'hC0_0F_00_80_80, 40'hC0_10_10_80_80, 40'hE0_1F_00_80_80,
        40'hE0_20_20_80_80};
    always #2 sys_clk_in = ~sys_clk_in;
    vosg_regs i_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .odd_field_in(odd_field_in),
        .pix_idx_in(pix_idx_in), .luma_in(luma_in), .chroma_in(chroma_in),
        .luma_out(luma_out), .chroma_out(chroma_out), .vert_ratio_value_out(ratio),
        .scale_mode_out(mode), .agc_gate_count_out(agc_cnt), .burst_gate_count_out(burst_cnt));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic complete_run();
        $display("counts: %0d compared, %0d mismatched", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer; entered just after a rising edge, request held until pready
    task automatic apb_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                            output logic [31:0] rd, output logic err);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        // no wait count assumed: loops until pready, the bench hang guard ends a stall
        do
        begin
            @(posedge sys_clk_in);
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    task automatic apb_wr(input logic [11:0] addr, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        apb_xfer(1'b1, addr, {24'h000000, d}, rd, err);
    endtask
    task automatic apb_rd(input logic [11:0] addr, input logic [7:0] exp);
        logic [31:0] rd;
        logic        err;
        apb_xfer(1'b0, addr, 32'h0000_0000, rd, err);
        check($sformatf("read at %h", addr), {24'h000000, exp}, rd);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_defaults();
        for (int i = 0; i < 8; i++)
            apb_rd(ofs_v[i], rst_v[i]);
        check("reset ratio", 32'h0, {19'h0, ratio});
        check("reset mode", 32'h1, {30'h0, mode});
        check("reset agc count", {24'h0, vosg_pkg::RST_AGC_GATE}, {24'h0, agc_cnt});
        check("reset burst count", {24'h0, vosg_pkg::RST_BURST_GATE}, {24'h0, burst_cnt});
        $display("test defaults done");
    endtask
    task automatic test_readback();
        logic [31:0] rd;
        logic        err;
        for (int i = 0; i < 8; i++)
            apb_wr(ofs_v[i], pat_v[i]);
        for (int i = 0; i < 8; i++)
            apb_rd(ofs_v[i], pat_v[i]);
        check("agc count", {24'h0, pat_v[4]}, {24'h0, agc_cnt});
        check("burst count", {24'h0, pat_v[5]}, {24'h0, burst_cnt});
        apb_xfer(1'b0, 12'h058, 32'h0, rd, err);
        check("unmapped error", 32'h1, {31'h0, err});
        $display("test readback done");
    endtask
    // set field, let the scaler outputs follow, compare ratio and mode
    task automatic scale_pick(input logic odd, input logic [12:0] r, input logic [1:0] m);
        odd_field_in <= odd;
        repeat (3) @(posedge sys_clk_in);
        check("ratio", {19'h0, r}, {19'h0, ratio});
        check("mode", {30'h0, m}, {30'h0, mode});
    endtask
    task automatic test_scale();
        logic [31:0] vs;
        // software value for a ratio of two
        vs = (32'h0001_0000 - (32'h2 - 32'h1) * 32'h0000_0200) & 32'h0000_1FFF;
        apb_wr(vosg_pkg::OFS_VS_HIGH_EVEN, 8'h95);
        apb_wr(vosg_pkg::OFS_VS_LOW_EVEN, 8'h3C);
        apb_wr(vosg_pkg::OFS_VS_HIGH_ODD, 8'h02);
        apb_wr(vosg_pkg::OFS_VS_LOW_ODD, 8'hA5);
        scale_pick(1'b0, 13'h153C, 2'b11);
        scale_pick(1'b1, 13'h02A5, 2'b00);
        apb_wr(vosg_pkg::OFS_VS_HIGH_ODD, 8'hBF);
        scale_pick(1'b1, 13'h1FA5, 2'b01);
        apb_wr(vosg_pkg::OFS_VS_HIGH_ODD, {3'b001, vs[12:8]});
        apb_wr(vosg_pkg::OFS_VS_LOW_ODD, vs[7:0]);
        scale_pick(1'b1, vs[12:0], 2'b01);
        scale_pick(1'b0, 13'h153C, 2'b11);
        $display("test scale done");
    endtask
    task automatic test_soft_reset();
        apb_wr(vosg_pkg::OFS_SOFT_RESET, 8'hA5);
        for (int i = 0; i < 8; i++)
            apb_rd(ofs_v[i], rst_v[i]);
        $display("test soft reset done");
    endtask
    task automatic test_shape();
        apb_wr(vosg_pkg::OFS_VS_HIGH_EVEN, 8'h20);
        foreach (shp_v[i])
        begin
            apb_wr(vosg_pkg::OFS_OUTPUT_FORMAT, shp_v[i][39:32]);
            luma_in   <= shp_v[i][31:24];
            chroma_in <= shp_v[i][15:8];
            repeat (3) @(posedge sys_clk_in);
            check("luma", {24'h0, shp_v[i][23:16]}, {24'h0, luma_out});
            check("chroma", {24'h0, shp_v[i][7:0]}, {24'h0, chroma_out});
        end
        $display("test shape done");
    endtask
    // one line of 0x40 then one of 0xC0: combed output must be their mean
    // first line bypassed: unwritten store entries would leak unknowns
    task automatic test_comb();
        for (int p = 0; p < 4; p++)
        begin
            pix_idx_in <= p[vosg_pkg::PIX_AW-1:0];
            chroma_in  <= 8'h40;
            @(posedge sys_clk_in);
        end
        apb_wr(vosg_pkg::OFS_VS_HIGH_EVEN, 8'h60);
        for (int p = 0; p < 4; p++)
        begin
            pix_idx_in <= p[vosg_pkg::PIX_AW-1:0];
            chroma_in  <= 8'hC0;
            @(posedge sys_clk_in);
            @(negedge sys_clk_in);
            check("comb chroma", 32'h80, {24'h0, chroma_out});
            @(posedge sys_clk_in);
        end
        $display("test comb done");
    endtask
    // ****************************************
    // main sequence and hang guard
    // ****************************************
    always @(posedge sys_clk_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            complete_run();
        end
    end
    initial
    begin
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        @(posedge sys_clk_in);
        test_defaults();
        test_readback();
        test_scale();
        test_soft_reset();
        test_shape();
        test_comb();
        complete_run();
    end
endmodule
